// ---- hvp_core_model.sv ----
// Core-side model: indirect commands and hv interrupt servicing
module hvp_core_model (
  input wire logic mclk_in,
  input wire logic busy_in,
  input wire logic [7:0] data_in,
  input wire logic irq_in,
  output hvp_pkg::hvp_cmd_s cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_irq = 0;
  initial cmd_out = '0;
  always @(posedge mclk_in) if (irq_in === 1'b1) n_irq++;
  // Status is only ever read, never written
  task automatic send(input logic [3:0] c, input logic [7:0] w);
    @(posedge mclk_in);
    cmd_out <= '{1'b1, c, w};
    @(posedge mclk_in);
    cmd_out <= '{1'b0, ~c, ~w};
  endtask : send
  task automatic read(input logic [3:0] c, output logic [7:0] d);
    send(c, 8'h00);
    #1 d = data_in;
  endtask : read
  // Waits for the transfer, polls busy, then takes the copy
  task automatic service(output logic [7:0] st, output int n);
    n = 0;
    repeat (25000) if (busy_in !== 1'b1) begin
      @(posedge mclk_in);
      #1;
    end
    while (busy_in === 1'b1 && n < 1000) begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    st = data_in;
  endtask : service
endmodule : hvp_core_model

// ---- hvp_pkg.sv ----
// Package: register layout, commands and timing constants for hv pin protect
package hvp_pkg;
  localparam int CLK_HZ = 50000000;
  // Wake pin monoflop timeout, in milliseconds
  localparam int WAKE_TIMEOUT_MS = 1300;
  localparam int WAKE_TIMEOUT_CYC = (CLK_HZ / 1000) * WAKE_TIMEOUT_MS;
  // Automatic status transfer busy time, in microseconds
  localparam int XFER_US = 10;
  localparam int XFER_CYC = (CLK_HZ / 1000000) * XFER_US;
  // Short-circuit qualify times, in microseconds
  localparam int BUS_SC_US = 20;
  localparam int BUS_SC_CYC = (CLK_HZ / 1000000) * BUS_SC_US;
  localparam int WAKE_SC_US = 400;
  localparam int WAKE_SC_CYC = (CLK_HZ / 1000000) * WAKE_SC_US;
  // Command codes carried in the command register
  localparam logic [3:0] CMD_NONE = 4'h0;
  localparam logic [3:0] CMD_RD_STATUS = 4'h1;
  localparam logic [3:0] CMD_WR_CFG_ONE = 4'h2;
  localparam logic [3:0] CMD_RD_CFG_ONE = 4'h3;
  localparam logic [3:0] CMD_WR_CFG_ZERO = 4'h4;
  localparam logic [3:0] CMD_RD_CFG_ZERO = 4'h5;
  // Config one bit positions
  localparam int C1_DIAG_PU = 0;
  localparam int C1_MONO_DIS = 1;
  localparam int C1_BUS_PASSIVE = 2;
  localparam int C1_REENABLE = 3;
  localparam int C1_WAKE_INPUT = 4;
  // Config zero bit positions
  localparam int C0_PSM_EN = 3;
  localparam int C0_WAKE_DRIVE = 4;
  // Status bit positions
  localparam int ST_WAKE_SC = 0;
  localparam int ST_BUS_SC = 2;
  localparam int ST_OVERTEMP = 3;
  localparam int ST_WAKE_EDGE = 4;
  localparam int ST_SUPPLY_LOW = 5;
  localparam logic [7:0] ST_USED_MASK = 8'h3D;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;

  typedef struct packed {
    logic valid;
    logic [3:0] cmd;
    logic [7:0] wdata;
  } hvp_cmd_s;

  typedef struct packed {
    logic bus_short;
    logic wake_short;
    logic overtemp;
    logic supply_low;
    logic wake_level;
  } hvp_sense_s;
endpackage : hvp_pkg

// ---- hvp_sync.sv ----
// Three-stage synchroniser with second/third stage agreement
module hvp_sync (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic d_in,
  output logic q_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } hvp_sync_s;
  hvp_sync_s st;
  hvp_sync_s next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.q;
endmodule : hvp_sync

// ---- hvp_top.sv ----
// High-voltage pin protection, wake pin control and interrupt status
module hvp_top (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire hvp_pkg::hvp_cmd_s cmd_in,
  input wire hvp_pkg::hvp_sense_s sense_in,
  input wire logic irq_enable_in,
  output logic busy_out,
  output logic [7:0] data_out,
  output logic hv_irq_line_out,
  output logic bus_enable_out,
  output logic wake_enable_out,
  output logic wake_drive_out,
  output logic diag_pullup_out
);
  typedef enum {XF_IDLE, XF_BUSY} hvp_xfer_e;

  typedef struct packed {
    hvp_xfer_e xfer;
    logic busy;
    logic [15:0] xcnt;
    logic [26:0] mono;
    logic [15:0] bus_sc_cnt;
    logic [15:0] wake_sc_cnt;
    logic [7:0] status;
    logic [7:0] cfg1;
    logic [7:0] cfg0;
    logic [7:0] data;
    logic irq;
    logic bus_en;
    logic wake_en;
    logic wake_drv;
    logic wake_last;
  } hvp_state_s;

  hvp_state_s st;
  hvp_state_s next_st;
  hvp_pkg::hvp_sense_s syn;
  logic [4:0] raw;
  logic [4:0] syn_v;

  assign raw = sense_in;
  assign syn = syn_v;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      hvp_sync u_sync (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .d_in(raw[gi]),
        .q_out(syn_v[gi])
      );
    end
  endgenerate

  always_comb begin
    logic [7:0] set_bits;
    logic event_now;
    logic reen;
    set_bits = 8'h00;
    event_now = 1'b0;
    reen = 1'b0;
    next_st = st;
    next_st.irq = 1'b0;
    // Command decode
    if (cmd_in.valid && st.xfer == XF_IDLE) begin
      case (cmd_in.cmd)
        hvp_pkg::CMD_RD_STATUS: next_st.data = st.status;
        hvp_pkg::CMD_RD_CFG_ONE: next_st.data = st.cfg1;
        hvp_pkg::CMD_RD_CFG_ZERO: next_st.data = st.cfg0;
        hvp_pkg::CMD_WR_CFG_ONE: begin
          next_st.cfg1 = cmd_in.wdata;
          next_st.cfg1[hvp_pkg::C1_REENABLE] = 1'b0;
          reen = cmd_in.wdata[hvp_pkg::C1_REENABLE];
        end
        hvp_pkg::CMD_WR_CFG_ZERO: begin
          next_st.cfg0 = cmd_in.wdata;
          if (cmd_in.wdata[hvp_pkg::C0_WAKE_DRIVE] && !st.wake_drv) begin
            next_st.mono = '0;
          end
        end
        default: begin
        end
      endcase
    end
    // Bus short qualify
    if (syn.bus_short && st.bus_en) begin
      next_st.bus_sc_cnt = st.bus_sc_cnt + 16'h0001;
    end else begin
      next_st.bus_sc_cnt = '0;
    end
    if (st.bus_sc_cnt == 16'(hvp_pkg::BUS_SC_CYC - 1)) begin
      set_bits[hvp_pkg::ST_BUS_SC] = 1'b1;
      if (!st.cfg1[hvp_pkg::C1_BUS_PASSIVE]) begin
        next_st.bus_en = 1'b0;
      end
    end
    // Wake short qualify
    if (syn.wake_short && st.wake_en) begin
      next_st.wake_sc_cnt = st.wake_sc_cnt + 16'h0001;
    end else begin
      next_st.wake_sc_cnt = '0;
    end
    if (st.wake_sc_cnt == 16'(hvp_pkg::WAKE_SC_CYC - 1)) begin
      set_bits[hvp_pkg::ST_WAKE_SC] = 1'b1;
      next_st.wake_en = 1'b0;
    end
    // Thermal event, always enabled
    if (syn.overtemp && !st.status[hvp_pkg::ST_OVERTEMP]) begin
      set_bits[hvp_pkg::ST_OVERTEMP] = 1'b1;
      next_st.wake_en = 1'b0;
    end
    // Wake edge in input mode
    next_st.wake_last = syn.wake_level;
    if (st.cfg1[hvp_pkg::C1_WAKE_INPUT] && syn.wake_level != st.wake_last) begin
      set_bits[hvp_pkg::ST_WAKE_EDGE] = 1'b1;
    end
    // Supply low is live, not latched
    if (st.cfg0[hvp_pkg::C0_PSM_EN] && syn.supply_low
        && !st.status[hvp_pkg::ST_SUPPLY_LOW]) begin
      event_now = 1'b1;
    end
    event_now = event_now | (|(set_bits & ~st.status));
    // Re-enable clears short and overtemp flags; new sets win over the clear
    if (reen) begin
      next_st.status[hvp_pkg::ST_BUS_SC] = 1'b0;
      next_st.status[hvp_pkg::ST_WAKE_SC] = 1'b0;
      next_st.status[hvp_pkg::ST_OVERTEMP] = 1'b0;
      // A trip in the same cycle keeps its pin off
      next_st.bus_en = !(set_bits[hvp_pkg::ST_BUS_SC]
        && !st.cfg1[hvp_pkg::C1_BUS_PASSIVE]);
      next_st.wake_en = !(set_bits[hvp_pkg::ST_WAKE_SC]
        | set_bits[hvp_pkg::ST_OVERTEMP]);
    end
    next_st.status = next_st.status | set_bits;
    next_st.status[hvp_pkg::ST_SUPPLY_LOW] =
      st.cfg0[hvp_pkg::C0_PSM_EN] & syn.supply_low;
    next_st.status = next_st.status & hvp_pkg::ST_USED_MASK;
    // Interrupt and automatic transfer
    if (event_now) begin
      next_st.irq = irq_enable_in;
      next_st.data = next_st.status;
      next_st.xfer = XF_BUSY;
      next_st.xcnt = '0;
    end else if (st.xfer == XF_BUSY) begin
      if (st.xcnt == 16'(hvp_pkg::XFER_CYC - 1)) begin
        next_st.xfer = XF_IDLE;
      end else begin
        next_st.xcnt = st.xcnt + 16'h0001;
      end
    end
    next_st.busy = (next_st.xfer == XF_BUSY);
    // Wake drive with monoflop
    next_st.wake_drv = next_st.cfg0[hvp_pkg::C0_WAKE_DRIVE] & next_st.wake_en;
    if (st.wake_drv && !st.cfg1[hvp_pkg::C1_MONO_DIS]) begin
      if (st.mono == 27'(hvp_pkg::WAKE_TIMEOUT_CYC - 1)) begin
        next_st.cfg0[hvp_pkg::C0_WAKE_DRIVE] = 1'b0;
        next_st.wake_drv = 1'b0;
        next_st.mono = '0;
      end else begin
        next_st.mono = st.mono + 27'h0000001;
      end
    end else if (!st.wake_drv) begin
      next_st.mono = '0;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st <= '{xfer: XF_IDLE, busy: 1'b0, xcnt: '0, mono: '0,
              bus_sc_cnt: '0, wake_sc_cnt: '0,
              status: hvp_pkg::STATUS_RESET,
              cfg1: hvp_pkg::CFG_RESET, cfg0: hvp_pkg::CFG_RESET,
              data: 8'h00, irq: 1'b0, bus_en: 1'b1, wake_en: 1'b1,
              wake_drv: 1'b0, wake_last: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign busy_out = st.busy;
  assign data_out = st.data;
  assign hv_irq_line_out = st.irq;
  assign bus_enable_out = st.bus_en;
  assign wake_enable_out = st.wake_en;
  assign wake_drive_out = st.wake_drv;
  assign diag_pullup_out = st.cfg1[hvp_pkg::C1_DIAG_PU];

  logic reen_w;
  assign reen_w = cmd_in.valid && st.xfer == XF_IDLE
    && cmd_in.cmd == hvp_pkg::CMD_WR_CFG_ONE
    && cmd_in.wdata[hvp_pkg::C1_REENABLE];

  AST_PASSIVE_KEEP: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    st.cfg1[hvp_pkg::C1_BUS_PASSIVE] && st.bus_en && !reen_w
    |=> st.bus_en) else $error("bus pin dropped in passive mode");
  AST_ACTIVE_OFF: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $rose(st.status[hvp_pkg::ST_BUS_SC]) && !st.cfg1[hvp_pkg::C1_BUS_PASSIVE]
    |-> !st.bus_en) else $error("bus pin kept on in active mode");
  AST_PULLUP: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    cmd_in.valid && !busy_out && cmd_in.cmd == hvp_pkg::CMD_WR_CFG_ONE
    |=> diag_pullup_out == $past(cmd_in.wdata[hvp_pkg::C1_DIAG_PU]))
    else $error("pull-up mismatch");
  AST_RSVD: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    st.status[7:6] == 2'b00 && !st.status[1])
    else $error("reserved status bit set");
  AST_COPY: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $rose(busy_out) |-> data_out == st.status)
    else $error("status not copied");
  AST_BUSY_LEN: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $rose(busy_out) |-> busy_out [*8])
    else $error("busy too short");
  AST_BUSY_END: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $rose(busy_out) |-> ##[1:600] !busy_out)
    else $error("busy never clears");
  AST_REEN: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    reen_w && !syn.bus_short |=> bus_enable_out && !st.status[2])
    else $error("re-enable failed");
  AST_SUPPLY: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    !st.cfg0[hvp_pkg::C0_PSM_EN] |=> !st.status[5])
    else $error("supply bit without monitor");
  // An event during busy restarts the transfer, so busy need not rise
  AST_IRQ: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    hv_irq_line_out |-> busy_out && data_out == st.status)
    else $error("irq without transfer");

  COV_BUS_SC: cover property (@(posedge mclk_in) $rose(st.status[2]));
  COV_WAKE_EDGE: cover property (@(posedge mclk_in) $rose(st.status[4]));
  COV_IRQ: cover property (@(posedge mclk_in) hv_irq_line_out);
  COV_REEN: cover property (@(posedge mclk_in) reen_w);
endmodule : hvp_top

// ---- testbench.sv ----
// Self-checking testbench for the hv pin protection block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0;
  logic rstn_in = 0;
  logic irq_enable_in = 0;
  hvp_pkg::hvp_sense_s sense_in = '0;
  hvp_pkg::hvp_cmd_s cmd_in;
  logic busy_out, hv_irq_line_out, bus_enable_out, wake_enable_out;
  logic wake_drive_out, diag_pullup_out;
  logic [7:0] data_out, v, w, d;
  int errors = 0, n_compared = 0, t = 0;
  always #10 mclk_in = ~mclk_in;
  hvp_top dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .cmd_in(cmd_in),
    .sense_in(sense_in), .irq_enable_in(irq_enable_in),
    .busy_out(busy_out), .data_out(data_out),
    .hv_irq_line_out(hv_irq_line_out), .bus_enable_out(bus_enable_out),
    .wake_enable_out(wake_enable_out), .wake_drive_out(wake_drive_out),
    .diag_pullup_out(diag_pullup_out));
  hvp_core_model core_u (.mclk_in(mclk_in), .busy_in(busy_out),
    .data_in(data_out), .irq_in(hv_irq_line_out), .cmd_out(cmd_in));
  function automatic logic [7:0] c1_rb(input logic [7:0] x);
    return x & 8'h17;
  endfunction : c1_rb
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic scen(input logic [7:0] c1, c0, input logic [4:0] m,
      input logic en, input logic [7:0] st, input logic [1:0] pins);
    int k, b;
    logic [7:0] s;
    @(posedge mclk_in);
    irq_enable_in <= en;
    core_u.send(hvp_pkg::CMD_WR_CFG_ONE, c1);
    core_u.send(hvp_pkg::CMD_WR_CFG_ZERO, c0);
    k = core_u.n_irq;
    @(posedge mclk_in);
    sense_in <= sense_in ^ m;
    core_u.service(s, b);
    chk(s, st);
    chk({6'h0, bus_enable_out, wake_enable_out}, {6'h0, pins});
    chk(8'(core_u.n_irq - k), {7'h0, en});
    chk({7'h0, b >= 499 && b <= 501}, 8'h01);
    core_u.read(hvp_pkg::CMD_RD_STATUS, s);
    chk(s, st);
    @(posedge mclk_in);
    sense_in <= sense_in & ~(m & 5'b11100);
    // Let the sense synchronisers settle before the next re-enable
    repeat (8) @(posedge mclk_in);
    t++;
    $display("test %0d done", t);
  endtask : scen
  // Watchdog sized well beyond the longest expected run
  initial begin
    #2000000;
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hD62C));
    repeat (2) @(posedge mclk_in);
    rstn_in <= 1'b1;
    #1;
    chk({2'b0, busy_out, hv_irq_line_out, bus_enable_out, wake_enable_out,
      wake_drive_out, diag_pullup_out}, 8'h0C);
    chk(data_out, 8'h00);
    core_u.read(hvp_pkg::CMD_RD_STATUS, d);
    chk(d, hvp_pkg::STATUS_RESET);
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      w = 8'($urandom) & 8'h18;
      core_u.send(hvp_pkg::CMD_WR_CFG_ONE, v);
      core_u.send(hvp_pkg::CMD_WR_CFG_ZERO, w);
      core_u.read(hvp_pkg::CMD_RD_CFG_ONE, d);
      chk(d & 8'h1F, c1_rb(v));
      core_u.read(hvp_pkg::CMD_RD_CFG_ZERO, d);
      chk(d & 8'h18, w);
      chk({7'h0, diag_pullup_out}, {7'h0, v[0]});
      chk({7'h0, wake_drive_out}, {7'h0, w[4]});
    end
    t++;
    $display("test %0d done", t);
    scen(8'h0C, 8'h00, 5'b10000, 1'b1, 8'h04, 2'b11);
    scen(8'h08, 8'h00, 5'b10000, 1'b0, 8'h04, 2'b01);
    scen(8'h08, 8'h00, 5'b00100, 1'b1, 8'h08, 2'b10);
    scen(8'h08, 8'h10, 5'b01000, 1'b1, 8'h01, 2'b10);
    scen(8'h18, 8'h00, 5'b00001, 1'b1, 8'h10, 2'b11);
    scen(8'h18, 8'h08, 5'b00010, 1'b1, 8'h30, 2'b11);
    core_u.send(hvp_pkg::CMD_WR_CFG_ONE, 8'h08);
    core_u.read(hvp_pkg::CMD_RD_STATUS, d);
    chk(d & 8'h0D, 8'h00);
    chk({6'h0, bus_enable_out, wake_enable_out}, 8'h03);
    t++;
    $display("test %0d done", t);
    wrap_up();
  end
endmodule : testbench
